/* hw/fie_encoder.v */
// fie_encoder.v: transmit coder stage with whitening, interleave, conv code.
// assumes: packet handler gives bytes with valid/ready and a last flag;
// modulator takes one coded bit per take pulse; Avalon-MM register port.
`timescale 1ns/1ps

// ==========================================================================
// top module
// Summary of operation
// - coder and interleaver are bypassed unless the coder enable bit is one.
// - coding covers data field and checksum; preamble and sync stay plain.
// - convolutional code, rate one half, constraint length four.
// - each input bit yields exactly two output bits.
// - coding always comes with interleaving; no separate control.
// - interleaver is a four by four bit matrix, two bytes.
// - bits written by rows, read by columns into the coder.
// - at least one extra byte follows the data for trellis termination.
// - interleaved amount per packet is a multiple of two bytes.
// - one or two pad bytes are added to make the length even.
// - length, payload and checksum bytes are interleaved then coded.
// - whitening, when enabled, comes before interleave and coding.
module fie_encoder
(
  input  wire        clk_sys,
  input  wire        rstn,
  // avalon-mm slave
  input  wire [5:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // packet handler: data after sync word
  input  wire        pkt_start,
  input  wire [7:0]  pkt_byte,
  input  wire        pkt_valid,
  input  wire        pkt_last,
  output reg         pkt_ready_reg,
  // modulator
  input  wire        mod_take,
  output reg         mod_bit_reg,
  output reg         mod_valid_reg,
  output reg         mod_done_reg
);

`include "fie_defs.vh"

  localparam ST_IDLE = 3'd0;
  localparam ST_BYP  = 3'd1;
  localparam ST_FILL = 3'd2;
  localparam ST_CODE = 3'd3;
  localparam ST_DONE = 3'd4;

  // ========================================================================
  // registers
  reg [7:0]  modem_config_one_reg;
  reg [7:0]  packet_control_zero_reg;
  reg [3:0]  poly_a_reg;
  reg [3:0]  poly_b_reg;
  reg [7:0]  pad_byte_reg;
  reg [15:0] byte_cnt_reg;
  reg        cfg_err_reg;
  reg        coding_reg;                     // latched per packet
  reg [2:0]  st_reg;
  reg [8:0]  wht_reg;
  reg [7:0]  hold_reg;                       // first byte of a pair
  reg        half_reg;                       // one byte of pair held
  reg        last_seen_reg;
  reg        pad_extra_reg;                  // extra trellis pair due
  reg [15:0] pair_reg;
  reg        load_reg;
  reg [7:0]  byp_reg;
  reg [3:0]  byp_cnt_reg;
  reg        phase_reg;                      // second coded bit pending
  reg [2:0]  cmem_reg;                       // coder history
  reg        cur_bit_reg;

  wire       mat_full;
  wire       mat_bit;
  wire       mat_take;
  wire       clr_pkt;
  wire [7:0] wht_byte;
  wire       whiten_on;
  wire       coder_en;
  wire [3:0] creg;
  wire       cfg_bad;

  assign coder_en  = modem_config_one_reg[`FIE_BIT_CODER_ENABLE];
  assign whiten_on = packet_control_zero_reg[`FIE_BIT_WHITENING_ENABLE];
  assign clr_pkt   = pkt_start;
  assign wht_byte  = whiten_on ? (pkt_byte ^ wht_reg[7:0]) : pkt_byte;
  assign creg      = {cur_bit_reg, cmem_reg};
  // coding is only legal with fixed length packets
  assign cfg_bad   = coder_en &&
    (packet_control_zero_reg[`FIE_MSB_LENGTH_CONFIG:
                             `FIE_LSB_LENGTH_CONFIG] != 2'b00);

  // parity of masked taps, used for both generator outputs
  function par4;
    input [3:0] v;
    begin
      par4 = ^v;
    end
  endfunction

  // pn9 whitening sequence, eight steps per byte
  function [8:0] pn9_step8;
    input [8:0] s;
    integer     i;
    reg   [8:0] t;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1)
        t = {t[5] ^ t[0], t[8:1]};
      pn9_step8 = t;
    end
  endfunction

  // ========================================================================
  // avalon slave: one wait cycle on every access
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      avs_waitrequest         <= 1'b1;
      avs_readdata            <= 32'h00000000;
      modem_config_one_reg    <= `FIE_RST_MODEM_CONFIG_ONE;
      packet_control_zero_reg <= `FIE_RST_PACKET_CONTROL_0;
      poly_a_reg              <= `FIE_RST_POLY_A;
      poly_b_reg              <= `FIE_RST_POLY_B;
      pad_byte_reg            <= `FIE_RST_PAD_BYTE;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
    begin
      avs_waitrequest <= 1'b1;
      if (avs_write && !avs_waitrequest)
      begin
        case (avs_address)
          `FIE_OFF_MODEM_CONFIG_ONE:
            modem_config_one_reg <= avs_writedata[7:0];
          `FIE_OFF_PACKET_CONTROL_0:
            packet_control_zero_reg <= avs_writedata[7:0];
          `FIE_OFF_POLY:
          begin
            poly_a_reg <= avs_writedata[3:0];
            poly_b_reg <= avs_writedata[7:4];
          end
          `FIE_OFF_PAD: pad_byte_reg <= avs_writedata[7:0];
          default: ;
        endcase
      end
    end
    // read data staged during the wait cycle; unmapped reads give zero
    if (rstn && avs_read && avs_waitrequest)
    begin
      case (avs_address)
        `FIE_OFF_MODEM_CONFIG_ONE:
          avs_readdata <= {24'h000000, modem_config_one_reg};
        `FIE_OFF_PACKET_CONTROL_0:
          avs_readdata <= {24'h000000, packet_control_zero_reg};
        `FIE_OFF_STATUS:
          avs_readdata <= {29'h00000000, cfg_err_reg, coding_reg,
                           (st_reg != ST_IDLE)};
        `FIE_OFF_POLY:
          avs_readdata <= {24'h000000, poly_b_reg, poly_a_reg};
        `FIE_OFF_PAD:   avs_readdata <= {24'h000000, pad_byte_reg};
        `FIE_OFF_BYTE_COUNT: avs_readdata <= {16'h0000, byte_cnt_reg};
        default:        avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // interleaver matrix
  // advance on the first coded bit, so the next matrix bit has settled
  // before the second one is taken, whatever the take rate
  assign mat_take = (st_reg == ST_CODE) && mod_take && mod_valid_reg &&
                    !phase_reg;

  fie_interleaver #(.N(4)) u_mat
  (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .clr         (clr_pkt),
    .load        (load_reg),
    .pair_in     (pair_reg),
    .bit_take    (mat_take),
    .full_reg    (mat_full),
    .bit_out_reg (mat_bit)
  );

  // ========================================================================
  // packet sequencer: bytes in, pairs loaded, coded bits out
  // flow control stalls the handler while the matrix is still draining,
  // which costs throughput but needs no buffer beyond one pair
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_reg        <= ST_IDLE;
      coding_reg    <= 1'b0;
      cfg_err_reg   <= 1'b0;
      byte_cnt_reg  <= 16'h0000;
      wht_reg       <= `FIE_WHITEN_SEED;
      hold_reg      <= 8'h00;
      half_reg      <= 1'b0;
      last_seen_reg <= 1'b0;
      pad_extra_reg <= 1'b0;
      pair_reg      <= 16'h0000;
      load_reg      <= 1'b0;
      byp_reg       <= 8'h00;
      byp_cnt_reg   <= 4'h0;
      phase_reg     <= 1'b0;
      cmem_reg      <= 3'b000;
      cur_bit_reg   <= 1'b0;
      pkt_ready_reg <= 1'b0;
      mod_bit_reg   <= 1'b0;
      mod_valid_reg <= 1'b0;
      mod_done_reg  <= 1'b0;
    end
    else if (pkt_start)
    begin
      // coding implies interleaving; one bit selects both
      coding_reg    <= coder_en;
      cfg_err_reg   <= cfg_bad;
      st_reg        <= coder_en ? ST_FILL : ST_BYP;
      byte_cnt_reg  <= 16'h0000;
      wht_reg       <= `FIE_WHITEN_SEED;
      half_reg      <= 1'b0;
      last_seen_reg <= 1'b0;
      pad_extra_reg <= 1'b0;
      load_reg      <= 1'b0;
      byp_cnt_reg   <= 4'h0;
      phase_reg     <= 1'b0;
      cmem_reg      <= 3'b000;
      pkt_ready_reg <= 1'b1;
      mod_valid_reg <= 1'b0;
      mod_done_reg  <= 1'b0;
    end
    else
    begin
      load_reg     <= 1'b0;
      mod_done_reg <= 1'b0;
      // flag follows live settings, visible before any packet starts
      cfg_err_reg  <= cfg_bad;
      case (st_reg)
        ST_IDLE:
          pkt_ready_reg <= 1'b0;
        // uncoded path: whitened bytes shifted out msb first
        ST_BYP:
        begin
          if (pkt_valid && pkt_ready_reg)
          begin
            byp_reg       <= wht_byte << 1;
            mod_bit_reg   <= wht_byte[7];
            mod_valid_reg <= 1'b1;
            byp_cnt_reg   <= 4'h7;
            pkt_ready_reg <= 1'b0;
            last_seen_reg <= pkt_last;
            wht_reg       <= pn9_step8(wht_reg);
            byte_cnt_reg  <= byte_cnt_reg + 16'h0001;
          end
          else if (mod_take && mod_valid_reg)
          begin
            if (byp_cnt_reg == 4'h0)
            begin
              mod_valid_reg <= 1'b0;
              pkt_ready_reg <= !last_seen_reg;
              if (last_seen_reg)
              begin
                st_reg       <= ST_IDLE;
                mod_done_reg <= 1'b1;
              end
            end
            else
            begin
              mod_bit_reg <= byp_reg[7];
              byp_reg     <= byp_reg << 1;
              byp_cnt_reg <= byp_cnt_reg - 4'h1;
            end
          end
        end
        // collect a byte pair; whitened before the matrix
        ST_FILL:
        begin
          if (!last_seen_reg && pkt_valid && pkt_ready_reg)
          begin
            wht_reg      <= pn9_step8(wht_reg);
            byte_cnt_reg <= byte_cnt_reg + 16'h0001;
            if (pkt_last)
            begin
              last_seen_reg <= 1'b1;
              pkt_ready_reg <= 1'b0;
            end
            if (half_reg)
            begin
              pair_reg <= {hold_reg, wht_byte};
              half_reg <= 1'b0;
              load_reg <= 1'b1;
              pkt_ready_reg <= 1'b0;
              // even count ends: two pad bytes follow
              pad_extra_reg <= pkt_last;
              st_reg <= ST_CODE;
            end
            else
            begin
              hold_reg <= wht_byte;
              half_reg <= 1'b1;
            end
          end
          else if (last_seen_reg && half_reg)
          begin
            // odd count: one pad byte ends the pair
            pair_reg <= {hold_reg, pad_byte_reg};
            half_reg <= 1'b0;
            load_reg <= 1'b1;
            st_reg   <= ST_CODE;
          end
          else if (last_seen_reg && pad_extra_reg)
          begin
            // full pad pair keeps the total even
            pair_reg      <= {pad_byte_reg, pad_byte_reg};
            pad_extra_reg <= 1'b0;
            load_reg      <= 1'b1;
            st_reg        <= ST_CODE;
          end
          else if (last_seen_reg)
          begin
            st_reg        <= ST_DONE;
            mod_valid_reg <= 1'b0;
          end
        end
        // two coded bits per matrix bit
        ST_CODE:
        begin
          if (!mod_valid_reg && mat_full && !load_reg)
          begin
            cur_bit_reg   <= mat_bit;
            mod_bit_reg   <= par4({mat_bit, cmem_reg} & poly_a_reg);
            mod_valid_reg <= 1'b1;
            phase_reg     <= 1'b0;
          end
          else if (mod_take && mod_valid_reg && !phase_reg)
          begin
            mod_bit_reg <= par4(creg & poly_b_reg);
            phase_reg   <= 1'b1;
          end
          else if (mod_take && mod_valid_reg && phase_reg)
          begin
            cmem_reg    <= creg[3:1];
            mod_bit_reg <= par4({mat_bit, creg[3:1]} & poly_a_reg);
            phase_reg   <= 1'b0;
            cur_bit_reg <= mat_bit;
            // matrix empties after its sixteenth bit
            if (!mat_full)
            begin
              mod_valid_reg <= 1'b0;
              st_reg        <= ST_FILL;
              pkt_ready_reg <= !last_seen_reg;
            end
          end
        end
        ST_DONE:
        begin
          st_reg       <= ST_IDLE;
          mod_done_reg <= 1'b1;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // fie_encoder

/* inc/fie_defs.vh */
// fie_defs.vh: register offsets, field positions, reset values and size
// counts for the packet coder stage.
// assumes: included by the design files by its bare name.
`ifndef FIE_DEFS_VH
`define FIE_DEFS_VH

// ==========================================================================
// register byte offsets (Avalon word addresses times four)
`define FIE_OFF_MODEM_CONFIG_ONE   6'h00
`define FIE_OFF_PACKET_CONTROL_0   6'h04
`define FIE_OFF_STATUS             6'h08
`define FIE_OFF_POLY               6'h0c
`define FIE_OFF_PAD                6'h10
`define FIE_OFF_BYTE_COUNT         6'h14

// ==========================================================================
// field positions
`define FIE_BIT_CODER_ENABLE       1
`define FIE_BIT_WHITENING_ENABLE   6
`define FIE_LSB_LENGTH_CONFIG      0
`define FIE_MSB_LENGTH_CONFIG      1
`define FIE_BIT_STAT_BUSY          0
`define FIE_BIT_STAT_CODING        1
`define FIE_BIT_STAT_CFG_ERR       2

// ==========================================================================
// reset values
`define FIE_RST_MODEM_CONFIG_ONE   8'h22
`define FIE_RST_PACKET_CONTROL_0   8'h45
`define FIE_RST_POLY_A             4'hf
`define FIE_RST_POLY_B             4'hb
`define FIE_RST_PAD_BYTE           8'h0b

// ==========================================================================
// sizes, counts and the whitening seed
`define FIE_MATRIX_BITS            16
`define FIE_CODER_MEM              3
`define FIE_WHITEN_SEED            9'h1ff

`endif

/* hw/fie_interleaver.v */
// fie_interleaver.v: 4x4 bit matrix interleaver, rows in, columns out.
// assumes: one clock, sync active-low reset, one loader stage upstream.
`timescale 1ns/1ps

// ==========================================================================
// matrix interleaver
module fie_interleaver
#(
  parameter N = 4
)
(
  input  wire               clk_sys,
  input  wire               rstn,
  input  wire               clr,
  input  wire               load,
  input  wire [2*N*N/2-1:0] pair_in,
  input  wire               bit_take,
  output reg                full_reg,
  output reg                bit_out_reg
);

  reg [N*N-1:0] mat_reg;
  reg [3:0]     rd_reg;

  // pair_in bit 15 is the first bit in (row 0 col 0); read down a column
  always @(posedge clk_sys)
  begin
    if (!rstn || clr)
    begin
      full_reg <= 1'b0;
      rd_reg   <= 4'h0;
      mat_reg  <= 16'h0000;
      bit_out_reg <= 1'b0;
    end
    else if (load && !full_reg)
    begin
      mat_reg  <= pair_in;
      full_reg <= 1'b1;
      rd_reg   <= 4'h0;
      bit_out_reg <= pair_in[15];
    end
    else if (bit_take && full_reg)
    begin
      rd_reg <= rd_reg + 4'h1;
      if (rd_reg == 4'hf)
        full_reg <= 1'b0;
      // next column-order index: row = rd[1:0], col = rd[3:2]
      bit_out_reg <= mat_reg[15 - {rd_next_row(rd_reg), 2'b00}
                             - rd_next_col(rd_reg)];
    end
  end

  function [3:0] rd_next_row;
    input [3:0] r;
    reg   [3:0] n;
    begin
      n = r + 4'h1;
      rd_next_row = {2'b00, n[1:0]};
    end
  endfunction

  function [3:0] rd_next_col;
    input [3:0] r;
    reg   [3:0] n;
    begin
      n = r + 4'h1;
      rd_next_col = {2'b00, n[3:2]};
    end
  endfunction

endmodule // fie_interleaver

/* tb/fie_encoder_checker.sv */
// fie_encoder_checker.sv: port assertions for the packet coder top.
// assumes: bound to fie_encoder; one clock, sync active-low reset.
`timescale 1ns/1ps

// ==========================================================================
// checker
module fie_encoder_checker
(
  input wire        clk_sys,
  input wire        rstn,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        pkt_start,
  input wire [7:0]  pkt_byte,
  input wire        pkt_valid,
  input wire        pkt_last,
  input wire        pkt_ready_reg,
  input wire        mod_take,
  input wire        mod_bit_reg,
  input wire        mod_valid_reg,
  input wire        mod_done_reg
);
  reg [11:0] bit_cnt_reg;

  // bits taken since packet start; checked a cycle after done
  always @(posedge clk_sys)
  begin
    if (!rstn || pkt_start)
      bit_cnt_reg <= 12'h000;
    else if (mod_take && mod_valid_reg)
      bit_cnt_reg <= bit_cnt_reg + 12'h001;
  end

  // bus answers: exactly one wait, answer stands one cycle
  a_wait_one: assert property (@(posedge clk_sys) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_answer_stands: assert property (@(posedge clk_sys) disable iff (!rstn)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  a_idle_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
    !avs_read && !avs_write && avs_waitrequest |=> $stable(avs_waitrequest))
    else $error("answer without request");
  a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    !avs_waitrequest && $past(avs_read) && ($past(avs_address) <= 6'h10)
    |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  // reset is checked through, so it carries no disable
  a_reset_quiet: assert property (@(posedge clk_sys)
    !rstn |=> avs_waitrequest && !mod_valid_reg && !pkt_ready_reg
    && !mod_done_reg && avs_readdata == 32'h0)
    else $error("outputs active after reset");
  a_bit_holds: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    mod_valid_reg && !mod_take |=> mod_valid_reg && $stable(mod_bit_reg))
    else $error("coded bit lost before take");
  a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    mod_done_reg |=> !mod_done_reg)
    else $error("done longer than one cycle");
  a_done_whole_bytes: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    mod_done_reg |=> bit_cnt_reg[2:0] == 3'h0)
    else $error("packet ended inside a byte");

  // main scenarios reached
  c_read: cover property (@(posedge clk_sys) !avs_waitrequest && avs_read);
  c_take: cover property (@(posedge clk_sys) mod_take && mod_valid_reg);
  c_done: cover property (@(posedge clk_sys) mod_done_reg);
endmodule // fie_encoder_checker

bind fie_encoder fie_encoder_checker fie_encoder_checker_i
(
  .clk_sys         (clk_sys),
  .rstn            (rstn),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_writedata   (avs_writedata),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .pkt_start       (pkt_start),
  .pkt_byte        (pkt_byte),
  .pkt_valid       (pkt_valid),
  .pkt_last        (pkt_last),
  .pkt_ready_reg   (pkt_ready_reg),
  .mod_take        (mod_take),
  .mod_bit_reg     (mod_bit_reg),
  .mod_valid_reg   (mod_valid_reg),
  .mod_done_reg    (mod_done_reg)
);

/* tb/fie_mod_model.sv */
// fie_mod_model.sv: modulator model, takes coded bits and logs them.
// assumes: gap sets idle cycles between takes, never fewer than one; zero and one are the fastest.
// assumes: no line coding is stacked on the coded stream
`timescale 1ns/1ps

// ==========================================================================
// modulator
module fie_mod_model
(
  input wire       clk_sys,
  input wire       rstn,
  input wire       mod_bit_reg,
  input wire       mod_valid_reg,
  input wire       mod_done_reg,
  input wire [3:0] gap,
  output reg       mod_take
);
  reg [3:0] wait_reg;
  reg       bit_log [0:1023];
  integer   n_bits;
  integer   n_done;

  // take is never high two cycles running, so no bit is taken twice
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      mod_take <= 1'b0;
      wait_reg <= 4'h0;
      n_bits   <= 0;
      n_done   <= 0;
    end
    else
    begin
      if (mod_done_reg)
        n_done <= n_done + 1;
      if (mod_valid_reg && !mod_take && wait_reg == 4'h0)
      begin
        mod_take <= 1'b1;
        bit_log[n_bits % 1024] <= mod_bit_reg;
        n_bits   <= n_bits + 1;
        wait_reg <= gap;
      end
      else
      begin
        mod_take <= 1'b0;
        if (wait_reg != 4'h0)
          wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule // fie_mod_model

/* tb/tb.sv */
// tb.sv: self-checking bench for the packet coder stage.
// assumes: fie_encoder with bound checker, modulator model beside it.
`timescale 1ns/1ps
`include "fie_defs.vh"

// ==========================================================================
// bench
module tb;
  reg         clk_sys = 1'b0;
  reg         rstn = 1'b0;
  reg  [5:0]  avs_address = 6'h00;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  reg         pkt_start = 1'b0;
  reg  [7:0]  pkt_byte = 8'h00;
  reg         pkt_valid = 1'b0;
  reg         pkt_last = 1'b0;
  wire        pkt_ready_reg;
  wire        mod_take;
  wire        mod_bit_reg;
  wire        mod_valid_reg;
  wire        mod_done_reg;
  reg  [3:0]  gap = 4'h0;
  reg  [7:0]  pkt_mem [0:7];
  reg  [7:0]  saved [0:7];
  reg  [24:0] rows [0:14];
  reg  [31:0] rd;
  integer     n_mismatch = 0;
  integer     total_checks = 0;
  integer     cycles = 0;
  integer     base;
  integer     i;

  always #5 clk_sys = ~clk_sys;

  fie_encoder fie_encoder_i
  (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pkt_start(pkt_start),
    .pkt_byte(pkt_byte), .pkt_valid(pkt_valid), .pkt_last(pkt_last),
    .pkt_ready_reg(pkt_ready_reg), .mod_take(mod_take),
    .mod_bit_reg(mod_bit_reg), .mod_valid_reg(mod_valid_reg),
    .mod_done_reg(mod_done_reg)
  );

  fie_mod_model fie_mod_model_i
  (
    .clk_sys(clk_sys), .rstn(rstn), .mod_bit_reg(mod_bit_reg),
    .mod_valid_reg(mod_valid_reg), .mod_done_reg(mod_done_reg),
    .gap(gap), .mod_take(mod_take)
  );

  task test_done;
  begin
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // a hang counts as a mismatch
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end

  task chk_reg(input [7:0] got, input [7:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: byte %h, want %h", $time, got, exp);
    end
  end
  endtask

  task chk_cnt(input [31:0] got, input [31:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: count %0d, want %0d", $time, got, exp);
    end
  end
  endtask

  // avalon master: hold the request until waitrequest is sampled low
  task av_rd(input [5:0] a, output [31:0] d);
  begin
    @(posedge clk_sys);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
  end
  endtask

  task av_wr(input [5:0] a, input [31:0] d);
  begin
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk_sys);
    avs_write <= 1'b0;
  end
  endtask

  // one packet from pkt_mem, then wait for done and count the bits
  task run_pkt(input integer n, input integer exp_bits);
    integer d0;
    integer k;
  begin
    base = fie_mod_model_i.n_bits;
    d0 = fie_mod_model_i.n_done;
    @(posedge clk_sys);
    pkt_start <= 1'b1;
    @(posedge clk_sys);
    pkt_start <= 1'b0;
    for (k = 0; k < n; k = k + 1)
    begin
      pkt_byte  <= pkt_mem[k];
      pkt_last  <= (k == n - 1);
      pkt_valid <= 1'b1;
      @(posedge clk_sys);
      while (pkt_ready_reg !== 1'b1)
        @(posedge clk_sys);
    end
    pkt_valid <= 1'b0;
    pkt_last  <= 1'b0;
    while (fie_mod_model_i.n_done == d0)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk_cnt(fie_mod_model_i.n_bits - base, exp_bits);
  end
  endtask

  // logged stream byte k of the last packet, first bit in the msb
  function [7:0] get_byte(input integer k);
    integer j;
  begin
    for (j = 0; j < 8; j = j + 1)
      get_byte[7 - j] = fie_mod_model_i.bit_log[(base + 8 * k + j) % 1024];
  end
  endfunction

  function [31:0] ones(input integer n);
    integer j;
  begin
    ones = 0;
    for (j = 0; j < n; j = j + 1)
      ones = ones + fie_mod_model_i.bit_log[(base + j) % 1024];
  end
  endfunction

  // two coded bits per bit, padded by one or two bytes to an even count
  function integer coded_bits(input integer n);
    coded_bits = 16 * (n + ((n % 2) ? 1 : 2));
  endfunction

  // reference: pairs read down columns, reset polys, first bit uses a
  function ref_bit(input [31:0] d, input integer j);
    integer    q;
    reg [3:0]  s;
    reg [15:0] p;
  begin
    s = 4'h0;
    for (q = 0; q <= j / 2; q = q + 1)
    begin
      p = (q < 16) ? d[31:16] : d[15:0];
      s = {p[15 - 4 * (q % 4) - (q % 16) / 4], s[3:1]};
    end
    ref_bit = ^(s & ((j % 2) ? `FIE_RST_POLY_B : `FIE_RST_POLY_A));
  end
  endfunction

  // ========================================================================
  // main sequence
  initial
  begin
    // rows: write flag, address, compare mask, value
    rows[0]  = {3'b000, `FIE_OFF_MODEM_CONFIG_ONE, 8'hff, 8'h22};
    rows[1]  = {3'b000, `FIE_OFF_PACKET_CONTROL_0, 8'hff, 8'h45};
    rows[2]  = {3'b000, `FIE_OFF_POLY, 8'hff, 8'hbf};
    rows[3]  = {3'b000, `FIE_OFF_PAD, 8'hff, 8'h0b};
    rows[4]  = {3'b000, 6'h18, 8'hff, 8'h00};
    rows[5]  = {3'b100, 6'h18, 8'hff, 8'hff};
    rows[6]  = {3'b000, 6'h18, 8'hff, 8'h00};
    rows[7]  = {3'b100, `FIE_OFF_PACKET_CONTROL_0, 8'hff, 8'h01};
    rows[8]  = {3'b000, `FIE_OFF_STATUS, 8'h04, 8'h04};
    rows[9]  = {3'b100, `FIE_OFF_PACKET_CONTROL_0, 8'hff, 8'h00};
    rows[10] = {3'b000, `FIE_OFF_STATUS, 8'h04, 8'h00};
    rows[11] = {3'b100, `FIE_OFF_PAD, 8'hff, 8'h00};
    rows[12] = {3'b000, `FIE_OFF_PAD, 8'hff, 8'h00};
    rows[13] = {3'b100, `FIE_OFF_STATUS, 8'hff, 8'hff};
    rows[14] = {3'b000, `FIE_OFF_PACKET_CONTROL_0, 8'hff, 8'h00};
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 15; i = i + 1)
    begin
      if (rows[i][24])
        av_wr(rows[i][21:16], {24'h0, rows[i][7:0]});
      else
      begin
        av_rd(rows[i][21:16], rd);
        chk_reg(rd[7:0] & rows[i][15:8], rows[i][7:0]);
      end
    end
    // coder off: bytes pass plain, msb first
    av_wr(`FIE_OFF_MODEM_CONFIG_ONE, 32'h20);
    pkt_mem[0] = 8'ha5;
    pkt_mem[1] = 8'h3c;
    pkt_mem[2] = 8'h01;
    run_pkt(3, 24);
    for (i = 0; i < 3; i = i + 1)
      chk_reg(get_byte(i), pkt_mem[i]);
    // coder on; zero data and zero pad give a zero stream
    av_wr(`FIE_OFF_MODEM_CONFIG_ONE, 32'h22);
    for (i = 0; i < 8; i = i + 1)
      pkt_mem[i] = 8'h00;
    gap = 4'h2;
    run_pkt(3, coded_bits(3));
    chk_cnt(ones(coded_bits(3)), 0);
    gap = 4'h0;
    run_pkt(4, coded_bits(4));
    // same packet twice must code the same way
    pkt_mem[0] = 8'ha5;
    pkt_mem[1] = 8'h3c;
    run_pkt(2, coded_bits(2));
    for (i = 0; i < 8; i = i + 1)
      saved[i] = get_byte(i);
    for (i = 0; i < 64; i = i + 1)
      chk_reg(fie_mod_model_i.bit_log[(base + i) % 1024],
              ref_bit(32'ha53c0000, i));
    gap = 4'h1;
    run_pkt(2, coded_bits(2));
    for (i = 0; i < 8; i = i + 1)
      chk_reg(get_byte(i), saved[i]);
    // pad contents reach the coder
    av_wr(`FIE_OFF_PAD, 32'hff);
    pkt_mem[0] = 8'h00;
    pkt_mem[1] = 8'h00;
    run_pkt(2, coded_bits(2));
    chk_cnt(ones(64) != 0, 1);
    // second reset in mid-run restores defaults
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    av_rd(`FIE_OFF_MODEM_CONFIG_ONE, rd);
    chk_reg(rd[7:0], 8'h22);
    // whitening on the uncoded path with the coder off, first byte xor 0xff
    av_wr(`FIE_OFF_PACKET_CONTROL_0, 32'h40);
    av_wr(`FIE_OFF_MODEM_CONFIG_ONE, 32'h20);
    run_pkt(1, 8);
    chk_reg(get_byte(0), 8'hff);
    test_done;
  end
endmodule // tb
